// ==== logic/lvd_pkg.sv ====
// package for the low-voltage detect logic: register map, field positions, timing
// assumes an 8-bit register port with byte addresses of our own choosing
package lvd_pkg;
    localparam int LVD_ADDR_W = 2;
    localparam logic [LVD_ADDR_W-1:0] LVD_CONTROL_ADDR = 2'h0;
    localparam logic [LVD_ADDR_W-1:0] LVD_DEBOUNCE_ADDR = 2'h1;
    localparam logic [LVD_ADDR_W-1:0] LVD_STATUS_ADDR = 2'h2;
    localparam int LVD_ENABLE_BIT = 7;
    localparam int LVD_SOURCE_BIT = 6;
    localparam int LVD_IRQEN_BIT = 5;
    localparam int LVD_FLAG_BIT = 3;
    localparam int LVD_THR_MSB = 2;
    localparam int LVD_THR_LSB = 0;
    localparam logic [7:0] LVD_CONTROL_RESET = 8'h00;
    localparam logic [7:0] LVD_DEBOUNCE_RESET = 8'h00;
    // debounce time = count * 8 cycles + 2 cycles
    localparam int LVD_DBC_SCALE_SHIFT = 3;
    localparam int LVD_DBC_EXTRA = 2;
    localparam int LVD_DBC_W = 12;

    typedef struct packed {
        logic enable;
        logic pinSource;
        logic irqEnable;
        logic [2:0] thresholdCode;
    } lvd_ctrl_t;

    typedef struct packed {
        logic irqReq;
        logic chipReset;
        logic wakeup;
    } lvd_event_t;
endpackage : lvd_pkg

// ==== logic/lvd_debounce.sv ====
// debounce counter for the comparator level
// assumes the comparator output is already synchronous to clk
`timescale 1ns/10ps
module lvd_debounce
    import lvd_pkg::*;
#(
    parameter int CNT_W = LVD_DBC_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic below,
    input wire logic [7:0] debounceCount,
    output logic detected
);
    logic [CNT_W-1:0] elapsed;
    logic [CNT_W-1:0] limit;
    logic counting;

    // below must last longer than the limit, so detection fires one cycle past it
    assign limit = CNT_W'({debounceCount, LVD_DBC_SCALE_SHIFT'(0)}) + CNT_W'(LVD_DBC_EXTRA);
    assign counting = run && below;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            elapsed <= '0;
        end else if (!counting) begin
            elapsed <= '0;
        end else if (elapsed <= limit) begin
            elapsed <= elapsed + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            detected <= 1'b0;
        end else begin
            detected <= counting && (elapsed >= limit);
        end
    end

    detect_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(detected) |-> $past(below, 1) && $past(below, 2))
        else $error("detection without sustained low level");
    dbc_early_a: assert property (@(posedge clk) disable iff (sys_rst)
        counting && (elapsed < limit) |=> !detected)
        else $error("detection before debounce time");
    dbc_fire_a: assert property (@(posedge clk) disable iff (sys_rst)
        counting && (elapsed >= limit) |=> detected)
        else $error("detection missing after debounce time");
endmodule : lvd_debounce

// ==== logic/lvd_logic.sv ====
// low-voltage detect control: registers, source select, debounce, flag, irq/reset
// assumes analog comparators outside; their outputs are synchronous to clk
// hysteresis lives in the analog part, so the debouncer sees clean levels only
// the threshold rule for the brownout level is left to software
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module lvd_logic
    import lvd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [LVD_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic supplyBelow,
    input wire logic senseBelow,
    input wire logic powerDownMode,
    input wire logic idleMode,
    output logic [2:0] thresholdCode,
    output logic comparatorEnable,
    output logic pinSourceSel,
    output logic irqReq,
    output logic chipReset,
    output logic wakeup
);
    lvd_ctrl_t ctrl;
    logic undervoltageFlag;
    logic [7:0] debounceCount;
    logic monitorBelow;
    logic detected;
    logic dbcRun;
    logic wrControl;
    logic wrDebounce;
    logic clearReq;
    logic next_flag;
    logic [7:0] controlView;
    logic [7:0] readMux;
    lvd_event_t next_evt;

    function automatic logic hit(input logic [LVD_ADDR_W-1:0] a,
                                 input logic [LVD_ADDR_W-1:0] target);
        hit = (a == target);
    endfunction : hit

    assign wrControl = regWrite && hit(regAddr, LVD_CONTROL_ADDR);
    assign wrDebounce = regWrite && hit(regAddr, LVD_DEBOUNCE_ADDR);
    assign clearReq = wrControl && !regWdata[LVD_FLAG_BIT];
    assign monitorBelow = ctrl.pinSource ? senseBelow : supplyBelow;
    // sleeping modes freeze the debouncer; it restarts from zero on wake
    assign dbcRun = ctrl.enable && !powerDownMode && !idleMode;

    // the set wins over a clear, and a clear while still low is ignored
    assign next_flag = detected ? 1'b1 :
                       (clearReq && !monitorBelow) ? 1'b0 : undervoltageFlag;

    assign controlView = {ctrl.enable, ctrl.pinSource, ctrl.irqEnable, 1'b0,
                          undervoltageFlag, ctrl.thresholdCode};
    assign readMux = hit(regAddr, LVD_CONTROL_ADDR) ? controlView :
                     hit(regAddr, LVD_DEBOUNCE_ADDR) ? debounceCount :
                     hit(regAddr, LVD_STATUS_ADDR) ?
                         {5'h00, detected, monitorBelow, dbcRun} : 8'h00;

    always_comb begin
        next_evt.irqReq = next_flag && ctrl.enable && ctrl.irqEnable;
        next_evt.chipReset = next_flag && ctrl.enable && ctrl.pinSource
                             && !ctrl.irqEnable;
        next_evt.wakeup = (next_evt.irqReq || next_evt.chipReset)
                          && (powerDownMode || idleMode);
    end

    lvd_debounce #(
        .CNT_W(LVD_DBC_W)
    ) u_debounce (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(dbcRun),
        .below(monitorBelow),
        .debounceCount(debounceCount),
        .detected(detected)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= lvd_ctrl_t'(6'h00);
            debounceCount <= LVD_DEBOUNCE_RESET;
        end else begin
            if (wrControl) begin
                ctrl.enable <= regWdata[LVD_ENABLE_BIT];
                ctrl.pinSource <= regWdata[LVD_SOURCE_BIT];
                ctrl.irqEnable <= regWdata[LVD_IRQEN_BIT];
                ctrl.thresholdCode <= regWdata[LVD_THR_MSB:LVD_THR_LSB];
            end
            if (wrDebounce) begin
                debounceCount <= regWdata;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            undervoltageFlag <= LVD_CONTROL_RESET[LVD_FLAG_BIT];
            irqReq <= 1'b0;
            chipReset <= 1'b0;
            wakeup <= 1'b0;
        end else begin
            undervoltageFlag <= next_flag;
            irqReq <= next_evt.irqReq;
            chipReset <= next_evt.chipReset;
            wakeup <= next_evt.wakeup;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdata <= 8'h00;
            thresholdCode <= 3'h0;
            comparatorEnable <= 1'b0;
            pinSourceSel <= 1'b0;
        end else begin
            regRdata <= regRead ? readMux : 8'h00;
            thresholdCode <= ctrl.thresholdCode;
            comparatorEnable <= ctrl.enable;
            pinSourceSel <= ctrl.pinSource;
        end
    end

    flag_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
        undervoltageFlag && monitorBelow && !detected |=> undervoltageFlag)
        else $error("flag cleared while voltage low");
    flag_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        detected |=> undervoltageFlag)
        else $error("detection did not set flag");
    no_detect_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        !ctrl.enable |=> !detected)
        else $error("detection while disabled");
    irq_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        !ctrl.irqEnable |=> !irqReq)
        else $error("irq without irq enable");
    irq_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
        next_flag && ctrl.enable && ctrl.irqEnable |=> irqReq)
        else $error("irq missing");
    supply_no_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
        !ctrl.pinSource |=> !chipReset)
        else $error("reset from supply source");
    pin_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
        next_flag && ctrl.enable && ctrl.pinSource && !ctrl.irqEnable |=> chipReset)
        else $error("pin detection reset missing");
    sleep_freeze_a: assert property (@(posedge clk) disable iff (sys_rst)
        (powerDownMode || idleMode) |=> !detected)
        else $error("debounce ran while sleeping");
    wake_a: assert property (@(posedge clk) disable iff (sys_rst)
        next_evt.irqReq && idleMode |=> wakeup)
        else $error("no wake on irq");

    // flag bookkeeping: a clear only lands when the monitored input is high
    // and no fresh detection competes with it in the same cycle
    flag_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        clearReq && !monitorBelow && !detected |=> !undervoltageFlag)
        else $error("valid clear ignored");

    flag_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        undervoltageFlag && !clearReq |=> undervoltageFlag)
        else $error("flag dropped without clear");

    flag_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
        !undervoltageFlag && !detected |=> !undervoltageFlag)
        else $error("flag set without detection");

    flag_low_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        undervoltageFlag && monitorBelow |=> undervoltageFlag)
        else $error("flag lost while input low");

    // interrupt and reset requests are levels that track the flag
    irq_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
        !next_flag |=> !irqReq)
        else $error("irq without flag");

    irq_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        !ctrl.enable |=> !irqReq && !chipReset)
        else $error("request while disabled");

    irq_needs_en_a: assert property (@(posedge clk) disable iff (sys_rst)
        !ctrl.enable || !ctrl.irqEnable |=> !irqReq)
        else $error("irq with a gate open");

    irq_en_view_a: assert property (@(posedge clk) disable iff (sys_rst)
        irqReq |-> comparatorEnable)
        else $error("irq while comparator off");

    reset_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl.irqEnable |=> !chipReset)
        else $error("reset with irq enabled");

    reset_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
        !next_flag |=> !chipReset)
        else $error("reset without flag");

    reset_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
        irqReq |-> !chipReset)
        else $error("irq and reset together");

    reset_src_a: assert property (@(posedge clk) disable iff (sys_rst)
        chipReset |-> pinSourceSel)
        else $error("reset with supply source");

    reset_en_view_a: assert property (@(posedge clk) disable iff (sys_rst)
        chipReset |-> comparatorEnable)
        else $error("reset while comparator off");

    // wakeup is only meaningful while asleep; awake it must stay low
    wake_pd_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
        next_evt.irqReq && powerDownMode |=> wakeup)
        else $error("no wake from power-down on irq");

    wake_pd_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
        next_evt.chipReset && powerDownMode |=> wakeup)
        else $error("no wake from power-down on reset");

    wake_idle_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
        next_evt.chipReset && idleMode |=> wakeup)
        else $error("no wake from idle on reset");

    wake_awake_a: assert property (@(posedge clk) disable iff (sys_rst)
        !powerDownMode && !idleMode |=> !wakeup)
        else $error("wake while awake");

    wake_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
        !next_evt.irqReq && !next_evt.chipReset |=> !wakeup)
        else $error("wake without cause");

    // the debouncer may only report what the selected input shows while running
    dbc_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        !dbcRun |=> !detected)
        else $error("detection while debounce stopped");

    dbc_src_a: assert property (@(posedge clk) disable iff (sys_rst)
        !monitorBelow |=> !detected)
        else $error("detection while input high");

    mon_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl.pinSource |-> monitorBelow == senseBelow)
        else $error("pin source not monitored");

    // comparator-side copies lag the register by one cycle on purpose
    thr_copy_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> thresholdCode == $past(ctrl.thresholdCode))
        else $error("threshold copy wrong");

    en_copy_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> comparatorEnable == $past(ctrl.enable))
        else $error("enable copy wrong");

    src_copy_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> pinSourceSel == $past(ctrl.pinSource))
        else $error("source copy wrong");

    // register port behaviour
    ctrl_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        wrControl |=> ctrl.thresholdCode == $past(regWdata[LVD_THR_MSB:LVD_THR_LSB]))
        else $error("threshold write lost");

    ctrl_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !wrControl |=> $stable(ctrl))
        else $error("control changed without write");

    dbc_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        wrDebounce |=> debounceCount == $past(regWdata))
        else $error("debounce write lost");

    dbc_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !wrDebounce |=> $stable(debounceCount))
        else $error("debounce changed without write");

    read_ctrl_a: assert property (@(posedge clk) disable iff (sys_rst)
        regRead && hit(regAddr, LVD_CONTROL_ADDR) |=> regRdata == $past(controlView))
        else $error("control readback wrong");

    read_dbc_a: assert property (@(posedge clk) disable iff (sys_rst)
        regRead && hit(regAddr, LVD_DEBOUNCE_ADDR) |=> regRdata == $past(debounceCount))
        else $error("debounce readback wrong");

    cov_irq_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(irqReq));
    cov_reset_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(chipReset));
    cov_clear_c: cover property (@(posedge clk) disable iff (sys_rst) $fell(undervoltageFlag));
    cov_wake_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(wakeup));
    cov_sticky_c: cover property (@(posedge clk) disable iff (sys_rst) undervoltageFlag && !monitorBelow);
endmodule : lvd_logic

// ==== tb/lvd_comparator_model.sv ====
// model of the analog supply and sense-pin comparators
// assumes levels in millivolts from the bench; hysteresis is left out
`timescale 1ns/10ps
module lvd_comparator_model (
    input wire logic [2:0] thresholdCode,
    input wire logic comparatorEnable,
    input wire logic [15:0] supplyMv,
    input wire logic [15:0] senseMv,
    output logic supplyBelow,
    output logic senseBelow
);
    localparam int TRIP [8] = '{1900, 2000, 2400, 2600, 3000, 3600, 3900, 4200};
    // a switched-off comparator never reports low, so stale levels cannot leak through
    assign supplyBelow = comparatorEnable && (supplyMv < TRIP[thresholdCode]);
    assign senseBelow = comparatorEnable && (senseMv < 16'h04b0);
endmodule : lvd_comparator_model

// ==== tb/lvd_logic_bench.sv ====
// testbench for lvd_logic: registers, debounce, flag, irq, reset, wakeup, sleep
// assumes the comparator model stands in for the analog side
`timescale 1ns/10ps
module lvd_logic_bench;
    import lvd_pkg::*;
    logic clk = 0, sys_rst = 1, regWrite = 0, regRead = 0, powerDownMode = 0, idleMode = 0;
    logic [LVD_ADDR_W-1:0] regAddr = 2'h0;
    logic [7:0] regWdata = 8'h00, regRdata;
    logic [15:0] supplyMv = 16'h1388, senseMv = 16'h05dc;
    logic [2:0] thresholdCode;
    logic supplyBelow, senseBelow, comparatorEnable, pinSourceSel, irqReq, chipReset, wakeup;
    int fail_count = 0, total_checks = 0, n;
    initial forever #20 clk = ~clk;
    lvd_logic dut(.clk, .sys_rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
        .supplyBelow, .senseBelow, .powerDownMode, .idleMode, .thresholdCode,
        .comparatorEnable, .pinSourceSel, .irqReq, .chipReset, .wakeup);
    lvd_comparator_model cmp(.thresholdCode, .comparatorEnable, .supplyMv, .senseMv,
        .supplyBelow, .senseBelow);
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task ck(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : ck
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    task rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 ck(regRdata, exp);
    endtask : rd
    task waitEv(input int b, input int lim);
        n = 0;
        while ({wakeup, chipReset, irqReq} >> b & 3'h1 ^ 3'h1) begin
            @(posedge clk);
            #1 n++;
            if (n > lim) begin
                fail_count++;
                stop_test();
            end
        end
    endtask : waitEv
    task testIdleRegs;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h3, 8'h00);
        wr(2'h0, 8'h27);
        supplyMv <= 16'h0fa0;
        repeat (24) @(posedge clk);
        #1 ck({6'h0, irqReq, comparatorEnable}, 8'h00);
        rd(2'h0, 8'h27);
        supplyMv <= 16'h1388;
        $display("regs and disable done");
    endtask : testIdleRegs
    task testSupply;
        wr(2'h1, 8'h02);
        // 3.9V trip, kept above the brown-out level
        wr(2'h0, 8'ha6);
        supplyMv <= 16'h0fa0;
        repeat (24) @(posedge clk);
        #1 ck({4'h0, irqReq, thresholdCode}, 8'h06);
        supplyMv <= 16'h0ed8;
        waitEv(0, 40);
        ck(8'(n >= 19 && n <= 21), 8'h01);
        ck({7'h0, chipReset}, 8'h00);
        rd(2'h0, 8'hae);
        rd(2'h2, 8'h07);
        wr(2'h0, 8'ha6);
        rd(2'h0, 8'hae);
        supplyMv <= 16'h1388;
        repeat (3) @(posedge clk);
        #1 ck({7'h0, irqReq}, 8'h01);
        wr(2'h0, 8'ha6);
        @(posedge clk);
        #1 ck({7'h0, irqReq}, 8'h00);
        rd(2'h0, 8'ha6);
        $display("supply source done");
    endtask : testSupply
    task testPin;
        wr(2'h1, 8'h00);
        wr(2'h0, 8'hc0);
        senseMv <= 16'h03e8;
        waitEv(1, 20);
        ck(8'(n >= 3 && n <= 5), 8'h01);
        ck({6'h0, irqReq, pinSourceSel}, 8'h01);
        rd(2'h0, 8'hc8);
        powerDownMode <= 1'b1;
        waitEv(2, 3);
        ck({7'h0, wakeup}, 8'h01);
        wr(2'h0, 8'he0);
        @(posedge clk);
        #1 ck({6'h0, irqReq, chipReset}, 8'h02);
        powerDownMode <= 1'b0;
        senseMv <= 16'h05dc;
        wr(2'h0, 8'he0);
        $display("pin source done");
    endtask : testPin
    task testSleep;
        idleMode <= 1'b1;
        senseMv <= 16'h03e8;
        repeat (20) @(posedge clk);
        #1 ck({7'h0, irqReq}, 8'h00);
        idleMode <= 1'b0;
        waitEv(0, 8);
        ck({7'h0, wakeup}, 8'h00);
        $display("sleep done");
    endtask : testSleep
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        testIdleRegs();
        testSupply();
        testPin();
        testSleep();
        stop_test();
    end
endmodule : lvd_logic_bench
